// File: hdl/civr_card.sv
/*
  Card end: raises one request level among three to six and answers
  the acknowledge cycle with a vector or stays silent to autovector.
  Assumes the master keeps level bits stable through the cycle, that
  the level switch and user inputs are synchronous to the clock, and
  that the master raises the strobe again once the vector is taken.
  Only one vectoring card may sit on a level; autovectored ones share.
*/
// Contract
// - Seven request levels, zero means quiescent
// - Card uses only levels three to six
// - Two-bit switch selects one driven line
// - Master ranks level seven highest
// - Master encodes requests to three bits
// - Levels one, two, seven use internal space
// - Level two is never shared
// - Master acknowledges only above current priority
// - Master puts level on address bits
// - Card ignores strobes, select and cycle codes
// - Matching vectoring card asserts vector-present quickly
// - No vector-present means master autovectors
// - Vector driven on acknowledge strobe alone
// - Vector stable before transfer acknowledge
// - Master captures vector, negates acknowledge strobe
// - Release vector-present and data after strobe
// - Autovectored card stays silent in acknowledge
// - Autovectored is the default mode
// - Status shows enable and requesting bits
// - Transfer acknowledge within 3000 ns
`timescale 1ns/100ps
module civr_card
  import civr_pkg::*;
#(
  // Autovectoring by default; vectored answers are for one-off builds
  parameter bit          VECTORED  = 1'b0,
  // Cycles from data on to transfer acknowledge, 1 to 15
  parameter int unsigned SETUP_CYC = VEC_SETUP_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Backplane
  civr_bus_if.card        bus,
  // Card user side
  input  wire logic [1:0] level_select,
  input  wire logic       int_enable,
  input  wire logic       int_event,
  input  wire logic       int_clear,
  input  wire civr_vec_t  vector_value,
  output logic [1:0]      status_bits
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_ACK   = 4'h4,
    ST_DONE  = 4'h8
  } civr_card_e;

  // Each _q is a register, its _d the value for the next edge
  civr_card_e state_q, state_d;
  logic       pend_q, pend_d;
  logic [7:1] req_q, req_d;
  logic       vp_q, vp_d, dt_q, dt_d, doe_q, doe_d;
  civr_vec_t  vec_q, vec_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] stat_q, stat_d;
  logic [2:0] lvl_q, lvl_d;
  logic [2:0] my_level;
  logic       match;

  // Switch code 0..3 lands on levels 3..6 only
  function automatic logic [2:0] switch_level(input logic [1:0] code);
    switch_level = LEVEL_EXT_LO + {1'b0, code};
  endfunction

  // Levels 1, 2 and 7 are out of reach, so no internal-space decode
  // and no sharing of the totem-pole line
  assign my_level = lvl_q;
  // Only the strobe and level bits are looked at
  assign match = !bus.acknowledge_strobe_n && pend_q
                 && (bus.level_address_bits == my_level);

  // Request group: pending flag, latched level, line enable, status
  always_comb begin
    pend_d = pend_q;
    lvl_d  = lvl_q;
    if (!pend_q) begin
      // Switch is sampled only while quiet, so a raised line never hops
      lvl_d = switch_level(level_select);
    end
    if (int_clear || !int_enable) begin
      pend_d = 1'b0;
    end
    if (int_event && int_enable) begin
      pend_d = 1'b1; // set wins over clear
    end
    req_d = '0;
    if (pend_q) begin
      req_d[my_level] = 1'b1;
    end
    stat_d = {int_enable, pend_q};
  end

  // Answer group: one pass per acknowledge strobe
  always_comb begin
    state_d = state_q;
    vp_d    = 1'b0;
    dt_d    = 1'b0;
    doe_d   = 1'b0;
    vec_d   = vec_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        // Autovectored card never answers
        if (VECTORED && match) begin
          vp_d    = 1'b1;
          doe_d   = 1'b1;
          // Frozen here, so a late change of the user value cannot
          // tear the byte the master is about to read
          vec_d   = vector_value;
          cnt_d   = 4'(SETUP_CYC);
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        vp_d  = 1'b1;
        doe_d = 1'b1;
        if (bus.acknowledge_strobe_n) begin
          // Master gave up early: let go at once all the same
          vp_d    = 1'b0;
          doe_d   = 1'b0;
          state_d = ST_DONE;
        end else if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          // Data held a full cycle before acknowledge
          dt_d    = 1'b1;
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        // Hold all three until the master raises the strobe
        vp_d  = 1'b1;
        doe_d = 1'b1;
        dt_d  = 1'b1;
        if (bus.acknowledge_strobe_n) begin
          // Drop everything the next edge, within 40 ns
          vp_d    = 1'b0;
          doe_d   = 1'b0;
          dt_d    = 1'b0;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // A strobe still low here belongs to the cycle just ended
        if (bus.acknowledge_strobe_n) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Request group registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      lvl_q  <= LEVEL_EXT_LO;
      req_q  <= '0;
      stat_q <= '0;
    end else begin
      pend_q <= pend_d;
      lvl_q  <= lvl_d;
      req_q  <= req_d;
      stat_q <= stat_d;
    end
  end

  // Answer group registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      vp_q    <= 1'b0;
      dt_q    <= 1'b0;
      doe_q   <= 1'b0;
      vec_q   <= VECTOR_RESET;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      vp_q    <= vp_d;
      dt_q    <= dt_d;
      doe_q   <= doe_d;
      vec_q   <= vec_d;
      cnt_q   <= cnt_d;
    end
  end

  // Every backplane output is a register, so no glitch reaches a
  // shared line
  assign bus.req_oe                  = req_q;
  assign bus.vector_present_oe       = vp_q;
  assign bus.transfer_acknowledge_oe = dt_q;
  assign bus.data_oe                 = doe_q;
  assign bus.low_data_byte_out       = vec_q;
  assign status_bits                 = stat_q;
endmodule

// File: hdl/civr_pkg.sv
/*
  Shared constants for the card interrupt request and acknowledge link.
  Assumes a single 25 MHz clock shared by both ends.
*/
package civr_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned NUM_LEVELS        = 7;
  localparam int unsigned VEC_PRESENT_MAX_NS = 100;
  localparam int unsigned VEC_SETUP_MIN_NS   = 15;
  localparam int unsigned REL_PRESENT_MAX_NS = 50;
  localparam int unsigned REL_DATA_MAX_NS    = 100;
  localparam int unsigned ACK_MAX_NS         = 3000;
  localparam int unsigned AUTOVEC_WAIT_NS    = 100;
  // Longest times round down, least times round up, never below one
  localparam int unsigned VEC_SETUP_CYC =
    (VEC_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_MAX_CYC = ACK_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned AUTOVEC_WAIT_CYC =
    (AUTOVEC_WAIT_NS / CLK_PERIOD_NS > 0) ?
    AUTOVEC_WAIT_NS / CLK_PERIOD_NS : 1;
  localparam logic [2:0] LEVEL_QUIET   = 3'h0;
  localparam logic [2:0] LEVEL_EXT_LO  = 3'h3;
  localparam logic [1:0] SEL_WIDTH_TAG = 2'h0;
  localparam logic [7:0] VECTOR_RESET  = 8'h00;
  typedef logic [7:0] civr_vec_t;
endpackage

// File: hdl/civr_bus_if.sv
/*
  Backplane interrupt wires between a plug-in card and the bus master.
  Active-low open-collector request lines are resolved from enables.
*/
`timescale 1ns/100ps
interface civr_bus_if;
  // Request lines, card side enables, resolved level seen by master
  logic [7:1] req_oe;
  logic [7:1] request_line_n;
  // Acknowledge cycle
  logic       acknowledge_strobe_n;
  logic [2:0] level_address_bits;
  logic       vector_present_oe;
  logic       vector_present_n;
  logic       transfer_acknowledge_oe;
  logic       transfer_acknowledge_n;
  logic       data_oe;
  logic [7:0] low_data_byte_out;
  logic [7:0] low_data_byte;
  // Open collector: a line is low when any driver enables it
  assign request_line_n         = ~req_oe;
  assign vector_present_n       = ~vector_present_oe;
  assign transfer_acknowledge_n = ~transfer_acknowledge_oe;
  assign low_data_byte          = data_oe ? low_data_byte_out : 8'hFF;
  modport card (
    output req_oe, vector_present_oe, transfer_acknowledge_oe,
    output data_oe, low_data_byte_out,
    input  acknowledge_strobe_n, level_address_bits
  );
  modport master (
    input  request_line_n, vector_present_n, transfer_acknowledge_n,
    input  low_data_byte,
    output acknowledge_strobe_n, level_address_bits
  );
endinterface

// File: hdl/civr_prio_enc.sv
/*
  Priority encoder: seven active-low request lines to a 3-bit level.
  Zero means no request pending.
*/
`timescale 1ns/100ps
module civr_prio_enc
  import civr_pkg::*;
(
  // Requests
  input  wire logic [7:1] request_line_n,
  // Encoded level
  output logic [2:0]      level
);
  always_comb begin
    level = LEVEL_QUIET;
    for (int i = 1; i <= 7; i++) begin
      if (!request_line_n[i]) begin
        level = 3'(i);
      end
    end
  end
endmodule

// File: hdl/civr_master.sv
/*
  Master end: encodes pending requests, runs acknowledge cycles and
  either reads a vector or autovectors.
  Assumes a vectoring card raises transfer acknowledge in bounded time;
  there is no bus-fault timeout here.
*/
`timescale 1ns/100ps
module civr_master
  import civr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Backplane
  civr_bus_if.master      bus,
  // Processor side
  input  wire logic [2:0] cpu_priority,
  output logic [2:0]      priority_input,
  output logic            vector_valid,
  output logic            autovector_request,
  output civr_vec_t       vector_out,
  output logic [2:0]      served_level
);
  typedef enum logic [3:0] {
    SM_IDLE = 4'h1,
    SM_WAIT = 4'h2,
    SM_READ = 4'h4,
    SM_END  = 4'h8
  } civr_mst_e;

  civr_mst_e  st_q, st_d;
  logic [2:0] enc, pri_q, lvl_q, lvl_d;
  logic       acknowledge_strobe_q, acknowledge_strobe_d, vv_q, vv_d, av_q, av_d;
  civr_vec_t  vec_q, vec_d;
  logic [1:0] w_q, w_d;

  civr_prio_enc u_enc (
    .request_line_n (bus.request_line_n),
    .level          (enc)
  );

  always_comb begin
    st_d   = st_q;
    acknowledge_strobe_d = acknowledge_strobe_q;
    lvl_d  = lvl_q;
    vv_d   = 1'b0;
    av_d   = 1'b0;
    vec_d  = vec_q;
    w_d    = w_q;
    case (st_q)
      SM_IDLE: begin
        if (enc > cpu_priority) begin
          lvl_d  = enc;
          acknowledge_strobe_d = 1'b1;
          w_d    = 2'(AUTOVEC_WAIT_CYC);
          st_d   = SM_WAIT;
        end
      end
      SM_WAIT: begin
        if (!bus.vector_present_n) begin
          st_d = SM_READ;
        end else if (w_q > 2'h1) begin
          w_d = w_q - 2'h1;
        end else begin
          av_d   = 1'b1;
          acknowledge_strobe_d = 1'b0;
          st_d   = SM_END;
        end
      end
      SM_READ: begin
        if (!bus.transfer_acknowledge_n) begin
          vec_d  = bus.low_data_byte;
          vv_d   = 1'b1;
          acknowledge_strobe_d = 1'b0;
          st_d   = SM_END;
        end
      end
      SM_END: begin
        // Wait for the card to release before the next cycle
        if (bus.vector_present_n && bus.transfer_acknowledge_n) begin
          st_d = SM_IDLE;
        end
      end
      default: begin
        st_d = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q   <= SM_IDLE;
      acknowledge_strobe_q <= 1'b0;
      lvl_q  <= LEVEL_QUIET;
      vv_q   <= 1'b0;
      av_q   <= 1'b0;
      vec_q  <= VECTOR_RESET;
      w_q    <= '0;
      pri_q  <= LEVEL_QUIET;
    end else begin
      st_q   <= st_d;
      acknowledge_strobe_q <= acknowledge_strobe_d;
      lvl_q  <= lvl_d;
      vv_q   <= vv_d;
      av_q   <= av_d;
      vec_q  <= vec_d;
      w_q    <= w_d;
      pri_q  <= enc;
    end
  end

  assign bus.acknowledge_strobe_n = ~acknowledge_strobe_q;
  assign bus.level_address_bits   = lvl_q;
  assign priority_input           = pri_q;
  assign vector_valid             = vv_q;
  assign autovector_request       = av_q;
  assign vector_out               = vec_q;
  assign served_level             = lvl_q;
endmodule

// File: tb/civr_link_checker.sv
/*
  Assertions on the backplane wires between a card and the bus master.
  Assumes the watched card is built as a vectoring card.
*/
`timescale 1ns/100ps
module civr_link_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Backplane
  input wire logic [7:1] req_oe,
  input wire logic       acknowledge_strobe_n,
  input wire logic [2:0] level_address_bits,
  input wire logic       vector_present_oe,
  input wire logic       transfer_acknowledge_oe,
  input wire logic       data_oe,
  input wire logic [7:0] low_data_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Level zero has no line, so pad bit zero
  wire logic [7:0] req8  = {req_oe, 1'b0};
  wire logic       match = req8[level_address_bits];
  ext_levels_a: assert property (!req_oe[1] && !req_oe[7])
    else $error("internal request level driven by card");
  level_two_a: assert property (!req_oe[2])
    else $error("level two driven by card");
  one_line_a: assert property ($onehot0(req_oe))
    else $error("more than one request line driven");
  vp_cause_a: assert property (
    $rose(vector_present_oe) |-> !$past(acknowledge_strobe_n) && $past(match))
    else $error("vector present without matching acknowledge");
  vp_fast_a: assert property (
    $fell(acknowledge_strobe_n) && match |-> ##[1:2] vector_present_oe)
    else $error("vector present late");
  setup_a: assert property (
    $rose(transfer_acknowledge_oe)
      |-> $past(data_oe) && $stable(low_data_byte))
    else $error("vector not set up before transfer acknowledge");
  release_a: assert property (
    $rose(acknowledge_strobe_n) |=> !vector_present_oe && !data_oe)
    else $error("card kept driving after strobe end");
  ack_bound_a: assert property (
    $fell(acknowledge_strobe_n) && match |-> ##[1:75] transfer_acknowledge_oe)
    else $error("transfer acknowledge late");
  strobe_only_a: assert property (
    data_oe |-> !acknowledge_strobe_n || !$past(acknowledge_strobe_n))
    else $error("data driven outside acknowledge");
  cover property ($rose(|req_oe));
  cover property ($rose(transfer_acknowledge_oe));
  cover property ($rose(acknowledge_strobe_n));
  cover property ($rose(data_oe));
endmodule

// File: tb/card_interrupt_vector_responder_tb_top.sv
/*
  Testbench: a vectoring and an autovectoring card, each facing a master.
  Assumes both pairs share the user-side stimulus.
*/
`timescale 1ns/100ps
module card_interrupt_vector_responder_tb_top;
  import civr_pkg::*;
  logic       clock = 0;
  logic       resetn = 0;
  logic [1:0] sel = 0;
  logic       en = 0, ev = 0, clr = 0;
  civr_vec_t  vec = 8'h00;
  logic [2:0] cpu = 3'h7;
  logic [2:0] lv, pi1, pi2, sl1, sl2, gl;
  logic       vv1, vv2, av1, av2, sv, sa, sx, sn;
  civr_vec_t  vo1, vo2, gv;
  logic [1:0] st1, st2;
  int         fail_count = 0, check_count = 0;
  civr_bus_if b1 ();
  civr_bus_if b2 ();
  always #20 clock = ~clock;
  civr_card #(.VECTORED(1'b1)) i_civr_card (.clock, .resetn, .bus(b1),
    .level_select(sel), .int_enable(en), .int_event(ev),
    .int_clear(clr), .vector_value(vec), .status_bits(st1));
  civr_master i_civr_master (.clock, .resetn, .bus(b1), .cpu_priority(cpu),
    .priority_input(pi1), .vector_valid(vv1), .autovector_request(av1),
    .vector_out(vo1), .served_level(sl1));
  civr_card #(.VECTORED(1'b0)) i_civr_card_auto (.clock, .resetn, .bus(b2),
    .level_select(sel), .int_enable(en), .int_event(ev),
    .int_clear(clr), .vector_value(vec), .status_bits(st2));
  civr_master i_civr_master_auto (.clock, .resetn, .bus(b2),
    .cpu_priority(cpu), .priority_input(pi2), .vector_valid(vv2),
    .autovector_request(av2), .vector_out(vo2), .served_level(sl2));
  civr_link_checker i_civr_link_checker (.clock, .resetn,
    .req_oe(b1.req_oe), .acknowledge_strobe_n(b1.acknowledge_strobe_n),
    .level_address_bits(b1.level_address_bits),
    .vector_present_oe(b1.vector_present_oe),
    .transfer_acknowledge_oe(b1.transfer_acknowledge_oe),
    .data_oe(b1.data_oe), .low_data_byte(b1.low_data_byte));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Gathers acknowledge outcomes of both pairs; stp waits for both
  task automatic watch(int n, bit stp);
    sv = 0;
    sa = 0;
    sx = 0;
    sn = 0;
    repeat (n) begin
      @(negedge clock);
      if (vv1 === 1'b1 && sv === 1'b0) begin
        gv = vo1;
        gl = sl1;
      end
      sv |= vv1;
      sa |= av2;
      sx |= !b2.vector_present_n | b2.data_oe | b2.transfer_acknowledge_oe;
      sn |= av1 | vv2;
      if (stp && sv === 1'b1 && sa === 1'b1) break;
    end
    if (stp && !(sv === 1'b1 && sa === 1'b1)) begin
      fail_count++;
      $display("MISMATCH ack wait expected done seen timeout");
      report_and_stop();
    end
  endtask
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1;
    @(negedge clock);
    check("priority idle", 8'h00, {5'h00, pi1});
    check("status idle", 8'h00, {6'h00, st1});
    for (int s = 0; s < 4; s++) begin
      lv = LEVEL_EXT_LO + 3'(s);
      sel = 2'(s);
      vec = 8'hA5 + 8'(s);
      cpu = 3'h7;
      en = 1;
      ev = 1;
      @(negedge clock);
      ev = 0;
      watch(4, 0);
      check("lines", {1'b0, ~(7'h01 << (lv - 3'h1))},
            {1'b0, b1.request_line_n});
      check("encoded", {5'h00, lv}, {5'h00, pi1});
      check("status set", 8'h03, {6'h00, st1});
      // Equal priority must not start an acknowledge
      cpu = lv;
      watch(8, 0);
      check("blocked", 8'h00, {6'h00, sv, sa});
      cpu = lv - 3'h1;
      watch(40, 1);
      check("vector", vec, gv);
      check("served", {5'h00, lv}, {5'h00, gl});
      check("auto silent", 8'h00, {7'h00, sx});
      check("cross outcome", 8'h00, {7'h00, sn});
      check("served auto", {5'h00, lv}, {5'h00, sl2});
      check("status auto", 8'h03, {6'h00, st2});
      check("held", {5'h00, lv}, {5'h00, pi2});
      cpu = 3'h7;
      clr = 1;
      @(negedge clock);
      clr = 0;
      watch(8, 0);
      check("status clear", 8'h02, {6'h00, st1});
      check("quiet", 8'h00, {5'h00, pi1});
    end
    ev = 1;
    @(negedge clock);
    ev = 0;
    en = 0;
    watch(4, 0);
    check("disabled", 8'h00, {5'h00, pi1});
    report_and_stop();
  end
endmodule
